// File: hdl/gtf_defs.vh
`ifndef GTF_DEFS_VH
`define GTF_DEFS_VH
// Register addresses
`define GTF_ADDR_PIN1_CTRL 8'h05
`define GTF_ADDR_CONV_SETUP 8'h06
`define GTF_ADDR_SEQ_ADDR 8'h07
`define GTF_ADDR_FILTER 8'h08
// Pin control fields
`define GTF_DIR_HI 7
`define GTF_DIR_LO 6
`define GTF_ISEL_HI 5
`define GTF_ISEL_LO 4
`define GTF_OSEL_HI 2
`define GTF_OSEL_LO 0
`define GTF_DIR_INPUT 2'h0
`define GTF_DIR_RSVD 2'h1
`define GTF_DIR_OPEN_DRAIN 2'h2
`define GTF_DIR_PUSH_PULL 2'h3
`define GTF_ISEL_OFF 2'h0
`define GTF_ISEL_CONV 2'h1
`define GTF_ISEL_SEQ 2'h2
`define GTF_ISEL_RSVD 2'h3
`define GTF_OSEL_HIZ 3'h0
`define GTF_OSEL_IRQ_LOW 3'h1
`define GTF_OSEL_IRQ_HIGH 3'h2
`define GTF_OSEL_LOW 3'h3
`define GTF_OSEL_HIGH 3'h4
`define GTF_OSEL_LSW 3'h5
`define GTF_OSEL_MOD 3'h6
`define GTF_OSEL_CLK 3'h7
// Conversion setup fields
`define GTF_DEST_HI 6
`define GTF_DEST_LO 4
`define GTF_KIND_HI 1
`define GTF_KIND_LO 0
`define GTF_CONV_MASK 8'h73
// Sequence address
`define GTF_SEQ_MIN 7'h3a
`define GTF_SEQ_MAX 7'h6f
`define GTF_SEQ_RESET 7'h3a
`define GTF_SEQ_HI 6
`define GTF_SEQ_LO 0
`define GTF_SEQ_TOP_BIT 7
// Filter fields
`define GTF_FTYPE_HI 5
`define GTF_FTYPE_LO 4
`define GTF_RATE_HI 3
`define GTF_RATE_LO 0
`define GTF_FILT_MASK 8'h7f
// Reset values of the configuration outputs
`define GTF_DEST_RESET 3'h0
`define GTF_KIND_RESET 2'h0
`define GTF_FTYPE_RESET 2'h0
`define GTF_RATE_RESET 4'h0
`define GTF_ZERO8 8'h00
`endif

// File: hdl/gtf_pin_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser with rising edge detect
module gtf_pin_sync (
  input wire ref_clk,
  input wire sys_rst,
  input wire pin_in,
  output reg level_r,
  output reg rise_r
);
  reg meta_r;
  reg sync_r;
  // Only sync_r reads meta_r; edge logic looks at later stages
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      level_r <= sync_r;
      rise_r <= sync_r & ~level_r;
    end
  end
endmodule // gtf_pin_sync

// File: hdl/gtf_out_mux.v
`timescale 1ns/1ps
`include "gtf_defs.vh"
// Pin output driver selection
module gtf_out_mux (
  input wire ref_clk,
  input wire sys_rst,
  input wire [1:0] dir,
  input wire [2:0] osel,
  input wire irq_level,
  input wire mod_active,
  input wire lsw_on,
  input wire sys_clk_div,
  output reg pin_out_r,
  output reg pin_oe_r
);
  reg val;
  reg oe;
  // Value and enable from function, then direction
  always @* begin
    val = 1'b0;
    oe = 1'b0;
    case (osel)
      `GTF_OSEL_HIZ: oe = 1'b0;
      `GTF_OSEL_IRQ_LOW: begin val = ~irq_level; oe = 1'b1; end
      `GTF_OSEL_IRQ_HIGH: begin val = irq_level; oe = 1'b1; end
      `GTF_OSEL_LOW: begin val = 1'b0; oe = 1'b1; end
      `GTF_OSEL_HIGH: begin val = 1'b1; oe = 1'b1; end
      `GTF_OSEL_LSW: begin val = 1'b0; oe = lsw_on; end
      `GTF_OSEL_MOD: begin val = mod_active; oe = 1'b1; end
      `GTF_OSEL_CLK: begin val = sys_clk_div; oe = 1'b1; end
      default: oe = 1'b0;
    endcase
    // Open drain only pulls low; input mode never drives
    if (dir == `GTF_DIR_OPEN_DRAIN && osel != `GTF_OSEL_LSW) begin
      oe = oe & ~val;
      val = 1'b0;
    end else if (dir != `GTF_DIR_PUSH_PULL && dir != `GTF_DIR_OPEN_DRAIN) begin
      oe = 1'b0;
      val = 1'b0;
    end
  end
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_out_r <= val;
      pin_oe_r <= oe;
    end
  end
endmodule // gtf_out_mux

// File: hdl/gtf_pin_regs.v
`timescale 1ns/1ps
`include "gtf_defs.vh"
// Overview of operation
// - Reserved codes in pin control discarded whole
// - Direction: input, reserved, open-drain, push-pull
// - Input function: off, conversion, sequence, reserved
// - Output: hiZ, irq low/high, constant levels
// - Low-side switch, modulator status, system clock
// - Edge wakes from sleep, then starts
// - Conversion setup write never starts conversion
// - Result goes to selected data register
// - Kind: single, continuous, duty cycled
// - Sequence address write never launches sequence
// - Out-of-range sequence address writes ignored
// - Address resets 0x3a; sequence starts there
// - Filter type: 50/60, 50, 60, sinc
// - Rate decode depends on filter type
module gtf_pin_regs (
  input wire ref_clk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  input wire pin1_in,
  output reg pin1_out_r,
  output reg pin1_oe_r,
  input wire irq_level,
  input wire mod_active,
  input wire lsw_on,
  input wire sys_clk_div,
  input wire sleep_power_state,
  input wire standby_power_state,
  output reg wake_req_r,
  output reg conv_start_r,
  output reg [2:0] pin_conv_destination_r,
  output reg [1:0] pin_conv_kind_r,
  output reg seq_start_r,
  output reg [6:0] seq_start_addr_r,
  output reg [1:0] filter_type_sel_r,
  output reg [3:0] rate_sel_r
);
  // ****************************************
  // Register storage
  // ****************************************
  reg [1:0] pin1_direction_sel_r;
  reg [1:0] pin1_input_function_r;
  reg [2:0] pin1_output_function_r;
  reg [7:0] conv_setup_r;
  reg [6:0] pin_sequence_start_addr_r;
  reg [7:0] filter_r;
  reg pend_conv_r;
  reg pend_seq_r;
  wire pin_level;
  wire pin_rise;
  wire pin_out_w;
  wire pin_oe_w;
  wire asleep;
  wire wr_ctrl;
  wire ctrl_ok;
  wire [1:0] w_dir;
  wire [1:0] w_isel;
  // Next-value terms
  reg [1:0] pin1_direction_sel_nxt;
  reg [1:0] pin1_input_function_nxt;
  reg [2:0] pin1_output_function_nxt;
  reg [7:0] conv_setup_nxt;
  reg [6:0] pin_sequence_start_addr_nxt;
  reg [7:0] filter_nxt;
  reg [7:0] reg_rdata_nxt;
  reg pend_conv_nxt;
  reg pend_seq_nxt;
  reg wake_req_nxt;
  reg conv_start_nxt;
  reg seq_start_nxt;
  // Decoded strobes and trigger qualifiers
  wire wr_conv;
  wire wr_seq;
  wire wr_filt;
  wire trig_armed;
  wire trig_conv;
  wire trig_seq;
  wire pend_any;

  // Validity of a write to the pin control register
  function ctrl_valid;
    input [7:0] d;
    begin
      ctrl_valid = (d[`GTF_DIR_HI:`GTF_DIR_LO] != `GTF_DIR_RSVD) &&
                   (d[`GTF_ISEL_HI:`GTF_ISEL_LO] != `GTF_ISEL_RSVD);
    end
  endfunction

  // Address range test for sequence start
  function seq_in_range;
    input [7:0] d;
    begin
      seq_in_range = (d[`GTF_SEQ_TOP_BIT] == 1'b0) && (d[`GTF_SEQ_HI:`GTF_SEQ_LO] >= `GTF_SEQ_MIN) &&
                     (d[`GTF_SEQ_HI:`GTF_SEQ_LO] <= `GTF_SEQ_MAX);
    end
  endfunction

  // Register select for one mapped address
  function addr_hit;
    input [7:0] a;
    input [7:0] sel;
    begin
      addr_hit = (a == sel);
    end
  endfunction

  assign wr_ctrl = reg_wr && addr_hit(reg_addr, `GTF_ADDR_PIN1_CTRL);
  assign wr_conv = reg_wr && addr_hit(reg_addr, `GTF_ADDR_CONV_SETUP);
  assign wr_seq = reg_wr && addr_hit(reg_addr, `GTF_ADDR_SEQ_ADDR);
  assign wr_filt = reg_wr && addr_hit(reg_addr, `GTF_ADDR_FILTER);
  assign ctrl_ok = ctrl_valid(reg_wdata);
  assign w_dir = reg_wdata[`GTF_DIR_HI:`GTF_DIR_LO];
  assign w_isel = reg_wdata[`GTF_ISEL_HI:`GTF_ISEL_LO];
  assign asleep = sleep_power_state | standby_power_state;

  // Only an input-direction pin with a trigger function reacts to edges
  assign trig_armed = pin_rise && (pin1_direction_sel_r == `GTF_DIR_INPUT);
  assign trig_conv = trig_armed && (pin1_input_function_r == `GTF_ISEL_CONV);
  assign trig_seq = trig_armed && (pin1_input_function_r == `GTF_ISEL_SEQ);
  assign pend_any = pend_conv_r | pend_seq_r;

  // ****************************************
  // Pin input path
  // ****************************************
  gtf_pin_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(pin1_in),
    .level_r(pin_level),
    .rise_r(pin_rise)
  );

  // ****************************************
  // Pin output path
  // ****************************************
  gtf_out_mux u_omux (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .dir(pin1_direction_sel_r),
    .osel(pin1_output_function_r),
    .irq_level(irq_level),
    .mod_active(mod_active),
    .lsw_on(lsw_on),
    .sys_clk_div(sys_clk_div),
    .pin_out_r(pin_out_w),
    .pin_oe_r(pin_oe_w)
  );

  // Output copies keep top outputs registered
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pin1_out_r <= 1'b0;
      pin1_oe_r <= 1'b0;
    end else begin
      pin1_out_r <= pin_out_w;
      pin1_oe_r <= pin_oe_w;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Whole write dropped if any field reserved; partial update would mix old and new
  always @* begin
    pin1_direction_sel_nxt = pin1_direction_sel_r;
    pin1_input_function_nxt = pin1_input_function_r;
    pin1_output_function_nxt = pin1_output_function_r;
    conv_setup_nxt = conv_setup_r;
    pin_sequence_start_addr_nxt = pin_sequence_start_addr_r;
    filter_nxt = filter_r;
    if (wr_ctrl && ctrl_ok) begin
      pin1_direction_sel_nxt = w_dir;
      pin1_input_function_nxt = w_isel;
      pin1_output_function_nxt = reg_wdata[`GTF_OSEL_HI:`GTF_OSEL_LO];
    end
    if (wr_conv) begin
      conv_setup_nxt = reg_wdata & `GTF_CONV_MASK;
    end
    if (wr_seq && seq_in_range(reg_wdata)) begin
      pin_sequence_start_addr_nxt = reg_wdata[`GTF_SEQ_HI:`GTF_SEQ_LO];
    end
    if (wr_filt) begin
      filter_nxt = reg_wdata & `GTF_FILT_MASK; // bit6 stored as written
    end
  end

  // Register state; reset leaves the pin an idle input with no function
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pin1_direction_sel_r <= `GTF_DIR_INPUT;
      pin1_input_function_r <= `GTF_ISEL_OFF;
      pin1_output_function_r <= `GTF_OSEL_HIZ;
      conv_setup_r <= `GTF_ZERO8;
      pin_sequence_start_addr_r <= `GTF_SEQ_RESET;
      filter_r <= `GTF_ZERO8;
    end else begin
      pin1_direction_sel_r <= pin1_direction_sel_nxt;
      pin1_input_function_r <= pin1_input_function_nxt;
      pin1_output_function_r <= pin1_output_function_nxt;
      conv_setup_r <= conv_setup_nxt;
      pin_sequence_start_addr_r <= pin_sequence_start_addr_nxt;
      filter_r <= filter_nxt;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data only moves on a read, so it stands until the next one
  always @* begin
    reg_rdata_nxt = reg_rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        `GTF_ADDR_PIN1_CTRL: reg_rdata_nxt = {pin1_direction_sel_r, pin1_input_function_r, 1'b0,
                                              pin1_output_function_r};
        `GTF_ADDR_CONV_SETUP: reg_rdata_nxt = conv_setup_r;
        `GTF_ADDR_SEQ_ADDR: reg_rdata_nxt = {1'b0, pin_sequence_start_addr_r};
        `GTF_ADDR_FILTER: reg_rdata_nxt = filter_r;
        default: reg_rdata_nxt = `GTF_ZERO8;
      endcase
    end
  end

  // Registered read data
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata_r <= `GTF_ZERO8;
    end else begin
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // ****************************************
  // Trigger handling
  // ****************************************
  // Edges only count in input direction; a pulse shorter than one clock may be missed
  always @* begin
    pend_conv_nxt = pend_conv_r;
    pend_seq_nxt = pend_seq_r;
    wake_req_nxt = 1'b0;
    conv_start_nxt = 1'b0;
    seq_start_nxt = 1'b0;
    if (trig_conv) begin
      // Wake first when asleep, start once awake
      pend_conv_nxt = asleep;
      wake_req_nxt = asleep;
      conv_start_nxt = ~asleep;
    end else if (trig_seq) begin
      pend_seq_nxt = asleep;
      wake_req_nxt = asleep;
      seq_start_nxt = ~asleep;
    end else if (pend_any && !asleep) begin
      conv_start_nxt = pend_conv_r;
      seq_start_nxt = pend_seq_r;
      pend_conv_nxt = 1'b0;
      pend_seq_nxt = 1'b0;
    end else if (pend_any) begin
      wake_req_nxt = 1'b1; // Held until power state reports normal
    end
  end

  // Trigger state; start strobes fall again the cycle after they rise
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_conv_r <= 1'b0;
      pend_seq_r <= 1'b0;
      wake_req_r <= 1'b0;
      conv_start_r <= 1'b0;
      seq_start_r <= 1'b0;
    end else begin
      pend_conv_r <= pend_conv_nxt;
      pend_seq_r <= pend_seq_nxt;
      wake_req_r <= wake_req_nxt;
      conv_start_r <= conv_start_nxt;
      seq_start_r <= seq_start_nxt;
    end
  end

  // ****************************************
  // Configuration outputs
  // ****************************************
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_conv_destination_r <= `GTF_DEST_RESET;
      pin_conv_kind_r <= `GTF_KIND_RESET;
      seq_start_addr_r <= `GTF_SEQ_RESET;
      filter_type_sel_r <= `GTF_FTYPE_RESET;
      rate_sel_r <= `GTF_RATE_RESET;
    end else begin
      pin_conv_destination_r <= conv_setup_r[`GTF_DEST_HI:`GTF_DEST_LO];
      pin_conv_kind_r <= conv_setup_r[`GTF_KIND_HI:`GTF_KIND_LO];
      seq_start_addr_r <= pin_sequence_start_addr_r;
      filter_type_sel_r <= filter_r[`GTF_FTYPE_HI:`GTF_FTYPE_LO];
      rate_sel_r <= filter_r[`GTF_RATE_HI:`GTF_RATE_LO]; // decoded with type downstream
    end
  end
endmodule // gtf_pin_regs

// File: verif/gtf_trig_host.sv
`timescale 1ns/1ps
// ****************
// Trigger pin host
// ****************
module gtf_trig_host (
  input wire logic ref_clk,
  input wire logic go,
  output logic pin_out
);
  logic [2:0] cnt_r;
  initial begin
    pin_out = 1'b0;
    cnt_r = 3'h0;
  end
  // High three clocks, low at least three, so no pulse is too short to catch
  always @(posedge ref_clk) begin
    if (go && cnt_r == 3'h0)
      cnt_r <= 3'h5;
    else if (cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
    pin_out <= (cnt_r > 3'h2);
  end
endmodule // gtf_trig_host

// File: verif/gtf_pin_regs_props.sv
`timescale 1ns/1ps
// **************
// Port checker
// **************
module gtf_pin_regs_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic sleep_power_state,
  input wire logic standby_power_state,
  input wire logic wake_req_r,
  input wire logic conv_start_r,
  input wire logic seq_start_r,
  input wire logic [2:0] pin_conv_destination_r,
  input wire logic [1:0] pin_conv_kind_r,
  input wire logic [6:0] seq_start_addr_r,
  input wire logic [1:0] filter_type_sel_r,
  input wire logic [3:0] rate_sel_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Start strobes are single pulses
  a_conv_one_cycle: assert property (conv_start_r |=> !conv_start_r)
    else $error("conv start longer than one cycle");
  a_seq_one_cycle: assert property (seq_start_r |=> !seq_start_r)
    else $error("seq start longer than one cycle");
  a_start_when_awake: assert property ((conv_start_r || seq_start_r) |->
    !$past(sleep_power_state) && !$past(standby_power_state)) else $error("start while powered down");
  a_wake_from_low: assert property ($rose(wake_req_r) |->
    $past(sleep_power_state) || $past(standby_power_state)) else $error("wake while awake");
  a_addr_in_range: assert property (seq_start_addr_r >= 7'h3a && seq_start_addr_r <= 7'h6f)
    else $error("seq address out of range");
  a_addr_good_write: assert property (reg_wr && reg_addr == 8'h07 && reg_wdata >= 8'h3a &&
    reg_wdata <= 8'h6f |-> ##2 seq_start_addr_r == $past(reg_wdata[6:0], 2)) else $error("seq address lost");
  a_addr_bad_write: assert property (reg_wr && reg_addr == 8'h07 && (reg_wdata < 8'h3a ||
    reg_wdata > 8'h6f) |-> ##2 $stable(seq_start_addr_r)) else $error("bad seq address taken");
  a_conv_setup_write: assert property (reg_wr && reg_addr == 8'h06 |-> ##2
    {pin_conv_destination_r, pin_conv_kind_r} == {$past(reg_wdata[6:4], 2), $past(reg_wdata[1:0], 2)})
    else $error("conv setup wrong");
  a_filter_write: assert property (reg_wr && reg_addr == 8'h08 |-> ##2
    {filter_type_sel_r, rate_sel_r} == $past(reg_wdata[5:0], 2)) else $error("filter setup wrong");
endmodule // gtf_pin_regs_chk
bind gtf_pin_regs gtf_pin_regs_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sleep_power_state(sleep_power_state),
  .standby_power_state(standby_power_state), .wake_req_r(wake_req_r), .conv_start_r(conv_start_r),
  .seq_start_r(seq_start_r), .pin_conv_destination_r(pin_conv_destination_r),
  .pin_conv_kind_r(pin_conv_kind_r), .seq_start_addr_r(seq_start_addr_r),
  .filter_type_sel_r(filter_type_sel_r), .rate_sel_r(rate_sel_r));

// File: verif/tb_top.sv
`timescale 1ns/1ps
// **********
// Testbench
// **********
module tb_top;
  logic ref_clk, sys_rst, reg_wr, reg_rd, go, irq, modact, lsw, clkdiv, slp, stb;
  logic [7:0] reg_addr, reg_wdata;
  wire [7:0] rdata;
  wire pin1_in, pout, poe, wake, cst, sst;
  wire [2:0] dst;
  wire [1:0] knd, fts;
  wire [6:0] sad;
  wire [3:0] rte;
  integer error_cnt, checks, i, n;
  gtf_pin_regs DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .pin1_in(pin1_in),
    .pin1_out_r(pout), .pin1_oe_r(poe), .irq_level(irq), .mod_active(modact), .lsw_on(lsw),
    .sys_clk_div(clkdiv), .sleep_power_state(slp), .standby_power_state(stb), .wake_req_r(wake),
    .conv_start_r(cst), .pin_conv_destination_r(dst), .pin_conv_kind_r(knd), .seq_start_r(sst),
    .seq_start_addr_r(sad), .filter_type_sel_r(fts), .rate_sel_r(rte));
  gtf_trig_host u_host (.ref_clk(ref_clk), .go(go), .pin_out(pin1_in));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task tick(input integer k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
    checks = checks + 1;
    if (e !== g) begin
      error_cnt = error_cnt + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  endtask
  // Strobes are held across exactly one sampling edge
  task wr(input [7:0] a, input [7:0] d);
    tick(1);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(2);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    tick(1);
    reg_rd = 1'b1; reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    chk("rdata", e, rdata);
  endtask
  // Bounded wait; 30 means nothing started
  task wait_st(input s);
    n = 0;
    while (n < 30 && (s ? sst : cst) !== 1'b1) begin
      tick(1);
      n = n + 1;
    end
  endtask
  task trig;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask
  task t_reset;
    rd(8'h07, 8'h3a);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    chk("sadr", 8'h3a, {1'b0, sad});
  endtask
  // Push-pull through every output code; expected from irq=1 mod=1 lsw=1 clk=0
  task t_ctrl;
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h05, 8'hc0 | i[7:0]);
      tick(3);
      chk("pinout", (i == 0) ? 8'h0 : ((i % 2) ? 8'h2 : 8'h3), {6'h0, poe, pout});
    end
    lsw = 1'b0;
    wr(8'h05, 8'hc5); tick(3);
    chk("lsw", 8'h0, {6'h0, poe, pout});
    lsw = 1'b1;
    {irq, modact, clkdiv} = 3'h1;
    wr(8'h05, 8'hc1);
    tick(3);
    chk("irqlo", 8'h3, {6'h0, poe, pout});
    wr(8'h05, 8'hc6);
    tick(3);
    chk("modst", 8'h2, {6'h0, poe, pout});
    wr(8'h05, 8'hc7);
    tick(3);
    chk("sclk", 8'h3, {6'h0, poe, pout});
    {irq, modact, clkdiv} = 3'h6;
    wr(8'h05, 8'h84); tick(3);
    chk("od_hi", 8'h0, {6'h0, poe, pout});
    wr(8'h05, 8'h83); tick(3);
    chk("od_lo", 8'h2, {6'h0, poe, pout});
    wr(8'h05, 8'h04); tick(3);
    chk("input", 8'h0, {6'h0, poe, pout});
    wr(8'h05, 8'hc4);
    wr(8'h05, 8'h44);
    wr(8'h05, 8'hf4);
    rd(8'h05, 8'hc4);
  endtask
  task t_cfg;
    wr(8'h06, 8'hff);
    rd(8'h06, 8'h73);
    chk("dest", 8'h7, {5'h0, dst});
    wait_st(1'b0);
    chk("idle", 8'd30, n[7:0]);
    wr(8'h06, 8'h41);
    chk("kind", 8'h41, {1'b0, dst, 2'h0, knd});
    wr(8'h07, 8'h6f);
    wr(8'h07, 8'h39);
    wr(8'h07, 8'h70);
    wr(8'h07, 8'hef);
    rd(8'h07, 8'h6f);
    wait_st(1'b1);
    chk("noseq", 8'd30, n[7:0]);
    wr(8'h08, 8'h3f);
    rd(8'h08, 8'h3f);
    wr(8'h08, 8'h1a);
    chk("filt", 8'h1a, {2'h0, fts, rte});
  endtask
  // Pin triggers, awake and from both low-power states
  task t_trig;
    wr(8'h05, 8'h10); trig; wait_st(1'b0);
    chk("conv", 8'h1, {7'h0, n < 30});
    wr(8'h07, 8'h50); wr(8'h05, 8'h20); trig; wait_st(1'b1);
    chk("seq", 8'hd0, {n < 30, sad});
    for (i = 0; i < 2; i = i + 1) begin
      {stb, slp} = i[0] ? 2'b10 : 2'b01;
      trig; tick(10);
      chk("wake", 8'h1, {7'h0, wake});
      wait_st(1'b1);
      chk("asleep", 8'd30, n[7:0]);
      {stb, slp} = 2'b00;
      wait_st(1'b1);
      chk("woken", 8'h1, {7'h0, n < 30});
      tick(4);
    end
    wr(8'h05, 8'hd0); trig; wait_st(1'b0);
    chk("outdir", 8'd30, n[7:0]);
    wr(8'h05, 8'h00); trig; wait_st(1'b0);
    chk("off", 8'd30, n[7:0]);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {sys_rst, reg_wr, reg_rd, go, slp, stb, clkdiv} = 7'h40;
    {irq, modact, lsw} = 3'h7;
    reg_addr = 8'h00; reg_wdata = 8'h00;
    error_cnt = 0; checks = 0;
    tick(4);
    sys_rst = 1'b0;
    t_reset; t_ctrl; t_cfg; t_trig;
    give_verdict;
  end
  // Hang guard, well past the few hundred cycles needed
  initial begin
    #60000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule // tb_top
